//--- inc/phy_led_misc_map.vh
// Summary of operation
// - Third LED selector bits 7:4 pick speed, tx, rx, collision, link, duplex or activity.
// - Codes 1000/1001 force LED on/off; 1010/1011 blink fast/slow.
// - 1100 link+receive, 1101 link+activity, 1110 duplex+collision; 0110, 1111 show nothing.
// - Link-combined modes hold LED on with link up; events toggle it to blink.
// - Link-and-activity mode blinks on activity whether link is up or down.
// - Duplex-collision mode holds on in full duplex; collisions make it toggle.
// - Stretch period bits 3:2 select 30, 60 or 100 ms; 11 reserved.
// - Pulse stretch bit 1 enables event stretching when set; resets to one.
// - Combined modes always stretch events regardless of the global enable bit.
// - Digital config bit 9 routes symbol error onto receive error output.
// - Transmit low-power bit 12 forces transmitter low power, zero differential.
// - Rise-time bits 11:10 load from slew pins sampled at the first enabled edge after reset; writable.
`ifndef PHY_LED_MISC_MAP_VH
`define PHY_LED_MISC_MAP_VH
`define LED_CFG_ADDR        5'h14
`define DIG_CFG_ADDR        5'h1a
`define TX_CTRL_ADDR        5'h1e
`define THIRD_INDICATOR_SELECT_SEL_RST        4'h2
`define LED_PERIOD_RST      2'h0
`define LED_CFG_RW_MASK     16'h00fe
`define DIG_CFG_RW_MASK     16'h0a00
`define TX_CTRL_RW_MASK     16'h1c00
`define SEL_SPEED           4'h0
`define SEL_TX              4'h1
`define SEL_RX              4'h2
`define SEL_COL             4'h3
`define SEL_LINK            4'h4
`define SEL_DUPLEX          4'h5
`define SEL_ACT             4'h7
`define SEL_ON              4'h8
`define SEL_OFF             4'h9
`define SEL_FAST            4'ha
`define SEL_SLOW            4'hb
`define SEL_LINK_RX         4'hc
`define SEL_LINK_ACT        4'hd
`define SEL_DUP_COL         4'he
`define CLK_MHZ             50
`define MS_CYCLES           (`CLK_MHZ * 1000)
`define STRETCH_30_MS       30
`define STRETCH_60_MS       60
`define STRETCH_100_MS      100
`define BLINK_FAST_MS       100
`define BLINK_SLOW_MS       400
`endif

//--- rtl/phy_led_and_misc_config_regs.v
`timescale 1ns/1ps
`include "phy_led_misc_map.vh"

module phy_led_and_misc_config_regs #(
    parameter [31:0] STRETCH_30_CYC  = `STRETCH_30_MS * `MS_CYCLES,
    parameter [31:0] STRETCH_60_CYC  = `STRETCH_60_MS * `MS_CYCLES,
    parameter [31:0] STRETCH_100_CYC = `STRETCH_100_MS * `MS_CYCLES,
    parameter [31:0] BLINK_FAST_CYC  = `BLINK_FAST_MS * `MS_CYCLES,
    parameter [31:0] BLINK_SLOW_CYC  = `BLINK_SLOW_MS * `MS_CYCLES
) (
    // Clock, reset, enable
    input  wire        mclk,
    input  wire        rst,
    input  wire        clk_en,
    // Management register port
    input  wire [4:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    // Straps
    input  wire [1:0]  tx_slew_config_pins,
    // Link status and events
    input  wire        speed_100,
    input  wire        link_up,
    input  wire        full_duplex,
    input  wire        tx_event,
    input  wire        rx_event,
    input  wire        col_event,
    // Receive error sources
    input  wire        rx_err_normal,
    input  wire        symbol_err,
    // Outputs
    output reg         third_led,
    output reg         mii_rx_err,
    output wire        tx_low_power,
    output wire [1:0]  tx_rise_time,
    output wire        mii_drive_strong
);

    reg  [3:0]  third_indicator_select_r;
    reg  [1:0]  led_stretch_period_sel_r;
    reg         pulse_stretch_en_r;
    reg         show_symbol_err_r;
    reg         mii_drive_r;
    reg         tx_low_power_r;
    reg  [1:0]  rise_time_r;
    reg         strap_pending_r;
    reg  [31:0] fast_cnt_r;
    reg  [31:0] blink_cnt_r;
    reg         blink_fast_r;
    reg         blink_slow_r;
    reg         led_nxt;
    reg  [31:0] period;
    wire        tx_st;
    wire        rx_st;
    wire        col_st;
    wire        combined;
    wire        stretch_on;
    wire        wr_ok;
    wire [2:0]  ev_raw;
    wire [2:0]  ev_st;

    // A write is taken only on an enabled edge, so a frozen block ignores the port.
    assign wr_ok = reg_wr & clk_en;

    // Each register has its own process so that a write to one can never
    // disturb the fields of another.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            third_indicator_select_r <= `THIRD_INDICATOR_SELECT_SEL_RST;
            led_stretch_period_sel_r <= `LED_PERIOD_RST;
            pulse_stretch_en_r       <= 1'b1;
        end
        else if (wr_ok && reg_addr == `LED_CFG_ADDR)
        begin
            third_indicator_select_r <= reg_wdata[7:4];
            led_stretch_period_sel_r <= reg_wdata[3:2];
            pulse_stretch_en_r       <= reg_wdata[1];
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            show_symbol_err_r <= 1'b0;
            mii_drive_r       <= 1'b0;
        end
        else if (wr_ok && reg_addr == `DIG_CFG_ADDR)
        begin
            show_symbol_err_r <= reg_wdata[9];
            mii_drive_r       <= reg_wdata[11];
        end
    end

    // Rise time strap is caught by the first enabled edge after release,
    // since an asynchronous reset may only load constants. A transmit control
    // write in that same cycle wins over the strap.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tx_low_power_r  <= 1'b0;
            rise_time_r     <= 2'h0;
            strap_pending_r <= 1'b1;
        end
        else if (clk_en)
        begin
            if (strap_pending_r)
            begin
                rise_time_r     <= tx_slew_config_pins;
                strap_pending_r <= 1'b0;
            end
            if (reg_wr && reg_addr == `TX_CTRL_ADDR)
            begin
                tx_low_power_r <= reg_wdata[12];
                rise_time_r    <= reg_wdata[11:10];
            end
        end
    end

    // Reserved bits read as zero; software must not rely on them.
    always @*
    begin
        if (reg_addr == `LED_CFG_ADDR)
        begin
            reg_rdata = {8'h00, third_indicator_select_r, led_stretch_period_sel_r,
                         pulse_stretch_en_r, 1'b0};
        end
        else if (reg_addr == `DIG_CFG_ADDR)
        begin
            reg_rdata = {4'h0, mii_drive_r, 1'b0, show_symbol_err_r, 9'h000};
        end
        else if (reg_addr == `TX_CTRL_ADDR)
        begin
            reg_rdata = {3'h0, tx_low_power_r, rise_time_r, 10'h000};
        end
        else
        begin
            reg_rdata = 16'h0000;
        end
    end

    assign tx_low_power     = tx_low_power_r;
    assign tx_rise_time     = rise_time_r;
    assign mii_drive_strong = mii_drive_r;

    // Reserved period code falls back to the longest setting.
    always @*
    begin
        case (led_stretch_period_sel_r)
            2'h0:    period = STRETCH_30_CYC;
            2'h1:    period = STRETCH_60_CYC;
            default: period = STRETCH_100_CYC;
        endcase
    end

    function is_combined;
        input [3:0] sel;
        begin
            is_combined = (sel == `SEL_LINK_RX) || (sel == `SEL_LINK_ACT) ||
                          (sel == `SEL_DUP_COL);
        end
    endfunction

    assign combined   = is_combined(third_indicator_select_r);
    assign stretch_on = pulse_stretch_en_r | combined;

    // Event order in the vectors: bit 2 transmit, bit 1 receive, bit 0 collision.
    assign ev_raw = {tx_event, rx_event, col_event};

    // Retriggerable stretchers: each event reloads the full period, so a burst
    // of traffic keeps the indication lit instead of flickering. The counters
    // run even while stretching is off, which keeps a mode change glitch free.
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : stretch_lane
            reg [31:0] cnt_r;
            always @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    cnt_r <= 32'h0000_0000;
                end
                else if (clk_en)
                begin
                    if (ev_raw[g])
                    begin
                        cnt_r <= period;
                    end
                    else if (cnt_r != 32'h0000_0000)
                    begin
                        cnt_r <= cnt_r - 32'h0000_0001;
                    end
                end
            end
            assign ev_st[g] = stretch_on ? (ev_raw[g] | (cnt_r != 32'h0000_0000)) : ev_raw[g];
        end
    endgenerate

    assign tx_st  = ev_st[2];
    assign rx_st  = ev_st[1];
    assign col_st = ev_st[0];

    // Each blink rate has its own counter, so the two rates need not divide
    // evenly and no divider is needed in the datapath.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            blink_cnt_r  <= 32'h0000_0000;
            blink_slow_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (blink_cnt_r >= BLINK_SLOW_CYC - 32'h0000_0001)
            begin
                blink_cnt_r  <= 32'h0000_0000;
                blink_slow_r <= ~blink_slow_r;
            end
            else
            begin
                blink_cnt_r <= blink_cnt_r + 32'h0000_0001;
            end
        end
    end

    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            fast_cnt_r   <= 32'h0000_0000;
            blink_fast_r <= 1'b0;
        end
        else if (clk_en)
        begin
            if (fast_cnt_r >= BLINK_FAST_CYC - 32'h0000_0001)
            begin
                fast_cnt_r   <= 32'h0000_0000;
                blink_fast_r <= ~blink_fast_r;
            end
            else
            begin
                fast_cnt_r <= fast_cnt_r + 32'h0000_0001;
            end
        end
    end

    // In combined modes the secondary event inverts the primary level, so a
    // stretched event shows as a blink whether the primary is on or off.
    always @*
    begin
        case (third_indicator_select_r)
            `SEL_SPEED:    led_nxt = speed_100;
            `SEL_TX:       led_nxt = tx_st;
            `SEL_RX:       led_nxt = rx_st;
            `SEL_COL:      led_nxt = col_st;
            `SEL_LINK:     led_nxt = link_up;
            `SEL_DUPLEX:   led_nxt = full_duplex;
            `SEL_ACT:      led_nxt = tx_st | rx_st;
            `SEL_ON:       led_nxt = 1'b1;
            `SEL_OFF:      led_nxt = 1'b0;
            `SEL_FAST:     led_nxt = blink_fast_r;
            `SEL_SLOW:     led_nxt = blink_slow_r;
            `SEL_LINK_RX:  led_nxt = link_up ^ (rx_st & blink_fast_r);
            `SEL_LINK_ACT: led_nxt = link_up ^ ((tx_st | rx_st) & blink_fast_r);
            `SEL_DUP_COL:  led_nxt = full_duplex ^ (col_st & blink_fast_r);
            default:       led_nxt = 1'b0;
        endcase
    end

    // The LED pin is registered so that decode glitches never reach the driver.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            third_led <= 1'b0;
        end
        else if (clk_en)
        begin
            third_led <= led_nxt;
        end
    end

    // The error output is registered so that switching its source never
    // glitches the pin in mid-cycle; the cost is one cycle of latency.
    always @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mii_rx_err <= 1'b0;
        end
        else if (clk_en)
        begin
            mii_rx_err <= show_symbol_err_r ? symbol_err : rx_err_normal;
        end
    end

endmodule // phy_led_and_misc_config_regs

//--- test/phy_led_chk.sv
`timescale 1ns/1ps
`include "phy_led_misc_map.vh"
module phy_led_chk (
    input wire        mclk,
    input wire        rst,
    input wire        clk_en,
    input wire [4:0]  reg_addr,
    input wire        reg_wr,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire [1:0]  tx_slew_config_pins,
    input wire        speed_100,
    input wire        link_up,
    input wire        full_duplex,
    input wire        tx_event,
    input wire        rx_event,
    input wire        col_event,
    input wire        rx_err_normal,
    input wire        symbol_err,
    input wire        third_led,
    input wire        mii_rx_err,
    input wire        tx_low_power,
    input wire [1:0]  tx_rise_time,
    input wire        mii_drive_strong
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire       led = clk_en && reg_addr == `LED_CFG_ADDR;
    wire       dig = clk_en && reg_addr == `DIG_CFG_ADDR;
    wire [3:0] sel = reg_rdata[7:4];
    a_rxerr_symbol: assert property (dig && reg_rdata[9] |=>
        mii_rx_err == $past(symbol_err)) else $error("symbol error not routed");
    a_rxerr_normal: assert property (dig && !reg_rdata[9] |=>
        mii_rx_err == $past(rx_err_normal)) else $error("receive error not routed");
    a_low_power: assert property (clk_en && reg_wr && reg_addr == `TX_CTRL_ADDR |=>
        tx_low_power == $past(reg_wdata[12])) else $error("low power output wrong");
    a_rise_field: assert property (clk_en && reg_wr && reg_addr == `TX_CTRL_ADDR |=>
        tx_rise_time == $past(reg_wdata[11:10])) else $error("rise time output wrong");
    a_force_on: assert property (led && sel == `SEL_ON |=> third_led)
        else $error("forced on failed");
    a_force_off: assert property (led && sel == `SEL_OFF |=> !third_led)
        else $error("forced off failed");
    a_unused_dark: assert property (led && (sel == 4'h6 || sel == 4'hf) |=> !third_led)
        else $error("unused code lit");
    a_link_level: assert property (led && sel == `SEL_LINK |=>
        third_led == $past(link_up)) else $error("link display wrong");
    a_speed_level: assert property (led && sel == `SEL_SPEED |=>
        third_led == $past(speed_100)) else $error("speed display wrong");
    c_link_rx: cover property (led && sel == `SEL_LINK_RX);
    c_symbol: cover property (dig && reg_rdata[9]);
    c_low_power: cover property (tx_low_power);
endmodule // phy_led_chk
bind phy_led_and_misc_config_regs phy_led_chk phy_led_chk_inst (.*);

//--- test/mgmt.sv
`timescale 1ns/1ps
`include "phy_led_misc_map.vh"
module mgmt (
    input  wire        mclk,
    input  wire [15:0] reg_rdata,
    output reg  [4:0]  reg_addr = 5'h00,
    output reg         reg_wr = 1'b0,
    output reg  [15:0] reg_wdata = 16'h0000
);
    function [15:0] msk(input [4:0] a);
        msk = a == `LED_CFG_ADDR ? `LED_CFG_RW_MASK : a == `DIG_CFG_ADDR ?
            `DIG_CFG_RW_MASK : a == `TX_CTRL_ADDR ? `TX_CTRL_RW_MASK : 16'h0000;
    endfunction
    task wr(input [4:0] a, input [15:0] d);
    begin
        @(posedge mclk);
        #1;
        reg_addr = a;
        reg_wdata = d & msk(a);
        reg_wr = 1'b1;
        @(posedge mclk);
        #1;
        reg_wr = 1'b0;
        // Released data is inverted so that nothing relies on a stale value.
        reg_wdata = ~reg_wdata;
    end
    endtask
    task rd(input [4:0] a, output [15:0] d);
    begin
        @(posedge mclk);
        #1;
        reg_addr = a;
        @(posedge mclk);
        d = reg_rdata;
    end
    endtask
endmodule // mgmt

//--- test/phy_led_and_misc_config_regs_test.sv
`timescale 1ns/1ps
`include "phy_led_misc_map.vh"
module phy_led_and_misc_config_regs_test;
    reg mclk = 1'b0, rst = 1'b1, clk_en = 1'b1;
    reg [1:0] tx_slew_config_pins, pins;
    reg speed_100, link_up, full_duplex, tx_event, rx_event, col_event;
    reg rx_err_normal, symbol_err, p;
    wire [4:0] reg_addr;
    wire [15:0] reg_wdata, reg_rdata;
    wire [1:0] tx_rise_time;
    wire reg_wr, third_led, mii_rx_err, tx_low_power, mii_drive_strong;
    integer n_errors = 0, compares = 0, i, n, m;
    reg [15:0] d, e;
    reg [4:0] a;
    reg [31:0] r;
    always #10 mclk = ~mclk;
    phy_led_and_misc_config_regs #(.STRETCH_30_CYC(20), .STRETCH_60_CYC(40),
        .STRETCH_100_CYC(60), .BLINK_FAST_CYC(8), .BLINK_SLOW_CYC(32))
        phy_led_and_misc_config_regs_inst (.*);
    mgmt mgmt_inst (.*);
    task chk(input [15:0] seen, input [15:0] exp);
    begin
        compares = compares + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    end
    endtask
    task report_and_stop;
    begin
        $display("errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task cyc(input integer k);
    begin
        repeat (k) @(posedge mclk);
        #1;
    end
    endtask
    task hi_len;
    begin
        n = 0;
        while (third_led === 1'b1 && n < 300)
        begin
            n = n + 1;
            cyc(1);
        end
    end
    endtask
    task pulse(input [2:0] m3);
    begin
        {tx_event, rx_event, col_event} = m3;
        cyc(1);
        {tx_event, rx_event, col_event} = 3'b000;
    end
    endtask
    task toggles(input integer k);
    begin
        n = 0;
        repeat (k)
        begin
            p = third_led;
            cyc(1);
            n = n + (third_led !== p);
        end
    end
    endtask
    function exp_led(input [3:0] c);
        case (c)
            4'h0: exp_led = speed_100;
            4'h1: exp_led = tx_event;
            4'h2: exp_led = rx_event;
            4'h3: exp_led = col_event;
            4'h4, 4'hc, 4'hd: exp_led = link_up;
            4'h5, 4'he: exp_led = full_duplex;
            4'h7: exp_led = tx_event | rx_event;
            4'h8: exp_led = 1'b1;
            default: exp_led = 1'b0;
        endcase
    endfunction
    initial
    begin
        r = $urandom(32'h297f_57df);
        r = $urandom;
        pins = r[1:0];
        tx_slew_config_pins = pins;
        {speed_100, link_up, full_duplex, tx_event, rx_event, col_event} = 6'h00;
        {rx_err_normal, symbol_err} = 2'b00;
        cyc(16);
        rst = 1'b0;
        cyc(1);
        // The strap must be latched once, not followed afterwards.
        tx_slew_config_pins = ~pins;
        mgmt_inst.rd(`LED_CFG_ADDR, d);
        chk(d, 16'h0022);
        mgmt_inst.rd(`DIG_CFG_ADDR, d);
        chk(d, 16'h0000);
        mgmt_inst.rd(`TX_CTRL_ADDR, d);
        chk(d, {4'h0, pins, 10'h000});
        mgmt_inst.rd(5'h00, d);
        chk(d, 16'h0000);
        for (i = 0; i < 9; i = i + 1)
        begin
            a = i % 3 == 0 ? `LED_CFG_ADDR : i % 3 == 1 ? `DIG_CFG_ADDR : `TX_CTRL_ADDR;
            r = $urandom;
            e = r[15:0] & mgmt_inst.msk(a);
            mgmt_inst.wr(a, e);
            mgmt_inst.rd(a, d);
            chk(d, e);
            if (a == `TX_CTRL_ADDR)
                chk({tx_low_power, tx_rise_time}, e[12:10]);
            else if (a == `DIG_CFG_ADDR)
                chk(mii_drive_strong, e[11]);
        end
        mgmt_inst.wr(`TX_CTRL_ADDR, 16'h0000);
        // A write while the block is frozen must leave the register untouched.
        clk_en = 1'b0;
        mgmt_inst.wr(`TX_CTRL_ADDR, 16'h1c00);
        clk_en = 1'b1;
        mgmt_inst.rd(`TX_CTRL_ADDR, d);
        chk(d, 16'h0000);
        for (i = 0; i < 2; i = i + 1)
        begin
            mgmt_inst.wr(`DIG_CFG_ADDR, i == 1 ? 16'h0200 : 16'h0000);
            {rx_err_normal, symbol_err} = i == 1 ? 2'b01 : 2'b10;
            cyc(2);
            chk(mii_rx_err, 1'b1);
        end
        for (i = 0; i < 32; i = i + 1)
        begin
            m = i % 16;
            r = $urandom;
            {speed_100, link_up, full_duplex} = r[2:0];
            {tx_event, rx_event, col_event} = m < 12 ? r[5:3] : 3'b000;
            if (m != 10 && m != 11)
            begin
                mgmt_inst.wr(`LED_CFG_ADDR, {8'h00, m[3:0], 4'h0});
                cyc(30);
                chk(third_led, exp_led(m[3:0]));
            end
        end
        {tx_event, rx_event, col_event} = 3'b000;
        mgmt_inst.wr(`LED_CFG_ADDR, 16'h00a0);
        toggles(64);
        chk(n >= 7 && n <= 9, 1'b1);
        mgmt_inst.wr(`LED_CFG_ADDR, 16'h00b0);
        toggles(256);
        chk(n >= 7 && n <= 9, 1'b1);
        for (i = 0; i < 4; i = i + 1)
        begin
            mgmt_inst.wr(`LED_CFG_ADDR, {8'h00, 4'h2, i[1:0], 2'b10});
            pulse(3'b010);
            hi_len;
            m = i == 0 ? 20 : i == 1 ? 40 : 60;
            chk(n >= m - 1 && n <= m + 3, 1'b1);
        end
        mgmt_inst.wr(`LED_CFG_ADDR, 16'h0022);
        pulse(3'b010);
        cyc(10);
        pulse(3'b010);
        hi_len;
        chk(n >= 19 && n <= 23, 1'b1);
        mgmt_inst.wr(`LED_CFG_ADDR, 16'h0020);
        pulse(3'b010);
        hi_len;
        chk(n <= 2, 1'b1);
        for (i = 12; i < 15; i = i + 1)
        begin
            link_up = i == 12;
            full_duplex = 1'b1;
            mgmt_inst.wr(`LED_CFG_ADDR, {8'h00, i[3:0], 4'h0});
            cyc(25);
            pulse(i == 12 ? 3'b010 : i == 13 ? 3'b100 : 3'b001);
            m = 0;
            repeat (30)
            begin
                m = m | (third_led !== exp_led(i[3:0]));
                cyc(1);
            end
            chk(m, 1);
            cyc(40);
            chk(third_led, exp_led(i[3:0]));
        end
        report_and_stop;
    end
    initial
    begin
        #200000;
        n_errors = n_errors + 1;
        report_and_stop;
    end
endmodule // phy_led_and_misc_config_regs_test
